// File: csf_forward.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module csf_forward import csf_pkg::*; (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  // register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  // receive links, pins change on the falling link clock edge
  input wire logic LINK_CLK_I,
  input wire logic [1:0] RX_AVAIL_I,
  input wire logic [3:0] RX_KIND_I,
  input wire logic [1:0] RX_LAST_I,
  input wire logic [15:0] RX_DATA_I,
  output logic [1:0] RX_TAKE_O,
  // mode strap
  input wire logic RAW_MODE_I,
  // csi output 0
  output logic CSI0_VALID_O,
  output logic CSI0_SOP_O,
  output logic CSI0_EOP_O,
  output logic [1:0] CSI0_KIND_O,
  output logic CSI0_SRC_O,
  output logic [7:0] CSI0_DATA_O,
  // csi output 1
  output logic CSI1_VALID_O,
  output logic CSI1_SOP_O,
  output logic CSI1_EOP_O,
  output logic [1:0] CSI1_KIND_O,
  output logic CSI1_SRC_O,
  output logic [7:0] CSI1_DATA_O,
  // transmitter rate
  output logic [1:0] CSI_TX_RATE_O
);
  typedef enum logic {ST_IDLE, ST_SEND} csf_state_t;

  localparam int SW = 1 + 4 * NPORT + 8 * NPORT;

  // register group
  logic [7:0] frm_hi_r, frm_hi_nxt;
  logic [7:0] frm_lo_r, frm_lo_nxt;
  logic [7:0] rate_r, rate_nxt;
  logic [7:0] pdis_r, pdis_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [1:0] rate_out_r, rate_out_nxt;
  logic [7:0] sts;
  logic rd_sts;

  // engine group
  csf_state_t st_r, st_nxt;
  logic sel_r, sel_nxt;
  logic drop_r, drop_nxt;
  logic grp_r, grp_nxt;
  logic group_r, group_nxt;
  csf_kind_t gkind_r, gkind_nxt;
  logic [1:0] take_r, take_nxt;
  logic first_r, first_nxt;
  logic bidx_r, bidx_nxt;
  logic merge_r, merge_nxt;
  logic rrl_r, rrl_nxt;
  logic synced_r, synced_nxt;
  logic done_r, done_nxt;
  logic fail_r, fail_nxt;
  logic fail_set;
  logic o_val, o_sop, o_eop;
  logic [7:0] o_data;

  // csi output registers
  logic c0_val_r, c0_sop_r, c0_eop_r, c0_src_r;
  logic [1:0] c0_kind_r;
  logic [7:0] c0_data_r;
  logic c1_val_r, c1_sop_r, c1_eop_r, c1_src_r;
  logic [1:0] c1_kind_r;
  logic [7:0] c1_data_r;

  // link side
  logic [SW-1:0] pins_s;
  logic lk_s, lk_d_r, stb;
  logic [1:0] av, lst;
  csf_kind_t kd [NPORT];
  logic [7:0] dt [NPORT];
  logic [1:0] adv;
  logic [FRAME_W-1:0] fnum [NPORT];
  logic [FRAME_W-1:0] fnxt [NPORT];

  // decode helpers
  logic [FRAME_W-1:0] fmax;
  logic [1:0] en, drain, ready, solo;
  csf_sync_t smode;
  logic rr_on, sync_on, asav_ok, all_av, kinds_eq, cat_cont, fsfe;
  csf_kind_t kd_cur;
  logic [FRAME_W-1:0] num_cur;

  // every link pin, the clock among them, shares one synchroniser delay
  csf_sync2 #(.W(SW)) u_sync (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .d_i({LINK_CLK_I, RX_AVAIL_I, RX_LAST_I, RX_KIND_I, RX_DATA_I}),
    .q_o(pins_s)
  );

  assign lk_s = pins_s[SW-1];
  assign av = pins_s[SW-2 -: 2];
  assign lst = pins_s[SW-4 -: 2];
  assign stb = lk_s && !lk_d_r;

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    assign kd[p] = csf_kind_t'(pins_s[16 + 2 * p +: 2]);
    assign dt[p] = pins_s[8 * p +: 8];
    csf_frame_num #(.FW(FRAME_W)) u_fnum (
      .clk_i(CORE_CLK_I),
      .srst_i(SRST_I),
      .max_i(fmax),
      .adv_i(adv[p]),
      .num_o(fnum[p]),
      .num_nxt_o(fnxt[p])
    );
  end

  assign fmax = {frm_hi_r, frm_lo_r};
  assign en = ~{pdis_r[PDIS_P1_BIT], pdis_r[PDIS_P0_BIT]};
  assign smode = csf_sync_t'(mode_r[MODE_SYNC_LSB +: 2]);
  assign rr_on = mode_r[MODE_RR_BIT];
  // should software set both, rotation wins and alignment stays off
  assign sync_on = (smode != SYNC_OFF) && !rr_on;
  assign asav_ok = mode_r[MODE_ASAV_BIT] && (smode != SYNC_CAT);
  assign drain = av & ~en;
  assign ready = av & en;
  assign solo = ready & {kd[1] == PK_LINE, kd[0] == PK_LINE} & {2{asav_ok}};
  assign all_av = ((av | ~en) == 2'b11) && (en != 2'b00);
  assign kinds_eq = (en != 2'b11) || (kd[0] == kd[1]);
  assign kd_cur = kd[sel_r];
  assign fsfe = (kd_cur == PK_FS) || (kd_cur == PK_FE);
  assign num_cur = (kd_cur == PK_FS) ? fnxt[sel_r] : fnum[sel_r];
  assign cat_cont = group_r && grp_r && (smode == SYNC_CAT) && (gkind_r == PK_LINE);
  assign rd_sts = REG_RD_I && (REG_ADDR_I == ADDR_STS);

  always_comb begin
    sts = 8'h00;
    sts[STS_FAIL_BIT] = fail_r;
    sts[STS_SYNC_BIT] = synced_r && sync_on;
  end

  always_comb begin
    frm_hi_nxt = frm_hi_r;
    frm_lo_nxt = frm_lo_r;
    rate_nxt = rate_r;
    pdis_nxt = pdis_r;
    mode_nxt = mode_r;
    rdata_nxt = rdata_r;
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        ADDR_FRM_HI: frm_hi_nxt = REG_WDATA_I;
        ADDR_FRM_LO: frm_lo_nxt = REG_WDATA_I;
        ADDR_RATE: rate_nxt = REG_WDATA_I & WMASK_RATE;
        ADDR_PDIS: pdis_nxt = REG_WDATA_I & WMASK_PDIS;
        ADDR_MODE: mode_nxt = REG_WDATA_I & WMASK_MODE;
        default: ;
      endcase
    end
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        ADDR_FRM_HI: rdata_nxt = frm_hi_r;
        ADDR_FRM_LO: rdata_nxt = frm_lo_r;
        ADDR_RATE: rdata_nxt = rate_r;
        ADDR_PDIS: rdata_nxt = pdis_r;
        ADDR_MODE: rdata_nxt = mode_r;
        ADDR_STS: rdata_nxt = sts;
        default: rdata_nxt = 8'h00;
      endcase
    end
    // the reserved code keeps the serialiser on the last legal rate
    rate_out_nxt = (rate_r[RATE_LSB +: 2] == RATE_RSVD) ? rate_out_r : rate_r[RATE_LSB +: 2];
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      frm_hi_r <= RST_FRM_HI;
      frm_lo_r <= RST_FRM_LO;
      rate_r <= RST_RATE;
      pdis_r <= RST_PDIS;
      mode_r <= RST_MODE;
      rdata_r <= 8'h00;
      rate_out_r <= RATE_800M;
    end else begin
      frm_hi_r <= frm_hi_nxt;
      frm_lo_r <= frm_lo_nxt;
      rate_r <= rate_nxt;
      pdis_r <= pdis_nxt;
      mode_r <= mode_nxt;
      rdata_r <= rdata_nxt;
      rate_out_r <= rate_out_nxt;
    end
  end

  always_comb begin
    st_nxt = st_r;
    sel_nxt = sel_r;
    drop_nxt = drop_r;
    grp_nxt = grp_r;
    group_nxt = group_r;
    gkind_nxt = gkind_r;
    take_nxt = take_r;
    first_nxt = first_r;
    bidx_nxt = bidx_r;
    merge_nxt = merge_r;
    rrl_nxt = rrl_r;
    synced_nxt = synced_r;
    done_nxt = done_r;
    fail_set = 1'b0;
    o_val = 1'b0;
    o_sop = 1'b0;
    o_eop = 1'b0;
    o_data = dt[sel_r];
    adv = 2'b00;
    // take only moves on a link edge, so the port never sees it change near its edge
    if (stb) begin
      case (st_r)
        ST_IDLE: begin
          if (drain != 2'b00) begin
            sel_nxt = !drain[0];
            drop_nxt = 1'b1;
            st_nxt = ST_SEND;
          end else if (sync_on && solo != 2'b00) begin
            sel_nxt = !solo[0];
            drop_nxt = 1'b0;
            st_nxt = ST_SEND;
          end else if (sync_on && all_av) begin
            if (kinds_eq) begin
              sel_nxt = !en[0];
              drop_nxt = 1'b0;
              group_nxt = 1'b1;
              grp_nxt = (en == 2'b11);
              gkind_nxt = kd[!en[0]];
              st_nxt = ST_SEND;
            end else begin
              fail_set = done_r;
              synced_nxt = 1'b0;
              done_nxt = 1'b0;
              // discard one head at a time, keeping a frame start, until both enabled ports' heads agree in kind
              sel_nxt = (kd[0] == PK_FS);
              drop_nxt = 1'b1;
              st_nxt = ST_SEND;
            end
          end else if (!sync_on && ready != 2'b00) begin
            sel_nxt = (rr_on && ready[!rrl_r]) ? !rrl_r : !ready[0];
            rrl_nxt = sel_nxt;
            drop_nxt = 1'b0;
            st_nxt = ST_SEND;
          end
          if (st_nxt == ST_SEND) begin
            take_nxt = 2'b00;
            take_nxt[sel_nxt] = 1'b1;
            first_nxt = 1'b1;
            bidx_nxt = 1'b0;
          end
        end
        ST_SEND: begin
          o_val = !drop_r;
          o_sop = first_r && !merge_r;
          o_eop = lst[sel_r] && !cat_cont;
          if (RAW_MODE_I && fsfe) begin
            o_data = bidx_r ? num_cur[15:8] : num_cur[7:0];
          end
          first_nxt = 1'b0;
          bidx_nxt = !bidx_r;
          if (lst[sel_r]) begin
            take_nxt = 2'b00;
            adv[sel_r] = (kd_cur == PK_FS) && !drop_r;
            if (group_r && grp_r) begin
              sel_nxt = 1'b1;
              grp_nxt = 1'b0;
              merge_nxt = cat_cont;
              take_nxt = 2'b10;
              first_nxt = 1'b1;
              bidx_nxt = 1'b0;
            end else begin
              st_nxt = ST_IDLE;
              group_nxt = 1'b0;
              merge_nxt = 1'b0;
              if (group_r && gkind_r == PK_FS) begin
                synced_nxt = 1'b1;
              end
              if (group_r && gkind_r == PK_FE && synced_r) begin
                done_nxt = 1'b1;
              end
            end
          end
        end
        default: st_nxt = ST_IDLE;
      endcase
    end
    if (!sync_on) begin
      synced_nxt = 1'b0;
      done_nxt = 1'b0;
    end
    fail_nxt = fail_set || (fail_r && !rd_sts);
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      lk_d_r <= 1'b0;
      st_r <= ST_IDLE;
      sel_r <= 1'b0;
      drop_r <= 1'b0;
      grp_r <= 1'b0;
      group_r <= 1'b0;
      gkind_r <= PK_FS;
      take_r <= 2'b00;
      first_r <= 1'b0;
      bidx_r <= 1'b0;
      merge_r <= 1'b0;
      rrl_r <= 1'b1;
      synced_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      c0_val_r <= 1'b0;
      c0_sop_r <= 1'b0;
      c0_eop_r <= 1'b0;
      c0_src_r <= 1'b0;
      c0_kind_r <= 2'h0;
      c0_data_r <= 8'h00;
      c1_val_r <= 1'b0;
      c1_sop_r <= 1'b0;
      c1_eop_r <= 1'b0;
      c1_src_r <= 1'b0;
      c1_kind_r <= 2'h0;
      c1_data_r <= 8'h00;
    end else begin
      lk_d_r <= lk_s;
      st_r <= st_nxt;
      sel_r <= sel_nxt;
      drop_r <= drop_nxt;
      grp_r <= grp_nxt;
      group_r <= group_nxt;
      gkind_r <= gkind_nxt;
      take_r <= take_nxt;
      first_r <= first_nxt;
      bidx_r <= bidx_nxt;
      merge_r <= merge_nxt;
      rrl_r <= rrl_nxt;
      synced_r <= synced_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      c0_val_r <= o_val;
      c1_val_r <= o_val && mode_r[MODE_REP_BIT];
      if (o_val) begin
        c0_sop_r <= o_sop;
        c0_eop_r <= o_eop;
        c0_src_r <= sel_r;
        c0_kind_r <= kd_cur;
        c0_data_r <= o_data;
      end
      if (o_val && mode_r[MODE_REP_BIT]) begin
        c1_sop_r <= o_sop;
        c1_eop_r <= o_eop;
        c1_src_r <= sel_r;
        c1_kind_r <= kd_cur;
        c1_data_r <= o_data;
      end
    end
  end

  assign REG_RDATA_O = rdata_r;
  assign RX_TAKE_O = take_r;
  assign CSI_TX_RATE_O = rate_out_r;
  assign CSI0_VALID_O = c0_val_r;
  assign CSI0_SOP_O = c0_sop_r;
  assign CSI0_EOP_O = c0_eop_r;
  assign CSI0_KIND_O = c0_kind_r;
  assign CSI0_SRC_O = c0_src_r;
  assign CSI0_DATA_O = c0_data_r;
  assign CSI1_VALID_O = c1_val_r;
  assign CSI1_SOP_O = c1_sop_r;
  assign CSI1_EOP_O = c1_eop_r;
  assign CSI1_KIND_O = c1_kind_r;
  assign CSI1_SRC_O = c1_src_r;
  assign CSI1_DATA_O = c1_data_r;

  take_onehot_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    $onehot0(take_r)) else $error("two receive ports taken at once");
  take_edge_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    !$past(stb) |-> $stable(take_r)) else $error("take moved away from a link edge");
  drain_drop_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    stb && st_r == ST_IDLE && drain != 2'b00 |=> drop_r && st_r == ST_SEND)
    else $error("blocked port not discarded");
  copy_out_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    c1_val_r |-> c0_val_r && c1_data_r == c0_data_r && c1_eop_r == c0_eop_r)
    else $error("copied output differs");
  zero_num_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    c0_val_r && c0_kind_r == PK_FS && $past(RAW_MODE_I && fmax == '0) |-> c0_data_r == 8'h00)
    else $error("frame number not zero with zero limit");
  sts_off_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    !sync_on |=> !synced_r) else $error("alignment shown while mode off");
  fail_clr_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    rd_sts && !fail_set |=> !fail_r) else $error("lost flag survived its read");
  fail_cause_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    $rose(fail_r) |-> $past(done_r)) else $error("lost flag before a good frame");
  group_wait_a: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    $rose(group_r) |-> $past(stb && all_av)) else $error("group started before all ports ready");
  rate_rst_a: assert property (@(posedge CORE_CLK_I)
    $past(SRST_I) |-> rate_r == RST_RATE && CSI_TX_RATE_O == RATE_800M)
    else $error("rate not at reset code");
endmodule

// File: csf_frame_num.sv
`timescale 1ns/1ps
module csf_frame_num import csf_pkg::*; #(
  parameter int FW = FRAME_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // limit and advance
  input wire logic [FW-1:0] max_i,
  input wire logic adv_i,
  // current and next number
  output logic [FW-1:0] num_o,
  output logic [FW-1:0] num_nxt_o
);
  logic [FW-1:0] num_r;
  logic [FW-1:0] num_nxt;

  if (FW < 2) begin : g_chk
    $error("csf_frame_num: frame number needs at least two bits");
  end

  always_comb begin
    if (max_i == '0) begin
      num_nxt = '0;
    end else if (num_r == '0 || num_r >= max_i) begin
      num_nxt = FW'(1);
    end else begin
      num_nxt = num_r + FW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      num_r <= '0;
    end else if (adv_i) begin
      num_r <= num_nxt;
    end
  end

  // a limit set to zero mid-frame must not leak a stale number into the end packet
  assign num_o = (max_i == '0) ? '0 : num_r;
  assign num_nxt_o = num_nxt;

  frame_wrap_a: assert property (@(posedge clk_i) disable iff (srst_i)
    adv_i && max_i != '0 |=> num_r != '0 && num_r <= $past(max_i))
    else $error("frame number left the range one to limit");
endmodule

// File: csf_pkg.sv
package csf_pkg;
  // register offsets
  localparam logic [7:0] ADDR_FRM_HI = 8'h1d;
  localparam logic [7:0] ADDR_FRM_LO = 8'h1e;
  localparam logic [7:0] ADDR_RATE = 8'h1f;
  localparam logic [7:0] ADDR_PDIS = 8'h20;
  localparam logic [7:0] ADDR_MODE = 8'h21;
  localparam logic [7:0] ADDR_STS = 8'h22;
  // reset values
  localparam logic [7:0] RST_FRM_HI = 8'h00;
  localparam logic [7:0] RST_FRM_LO = 8'h04;
  localparam logic [7:0] RST_RATE = 8'h02;
  localparam logic [7:0] RST_PDIS = 8'h30;
  localparam logic [7:0] RST_MODE = 8'h01;
  // writable bits of each register
  localparam logic [7:0] WMASK_RATE = 8'h0f;
  localparam logic [7:0] WMASK_PDIS = 8'hf0;
  localparam logic [7:0] WMASK_MODE = 8'hcf;
  // field positions
  localparam int RATE_LSB = 0;
  localparam int PDIS_P0_BIT = 4;
  localparam int PDIS_P1_BIT = 5;
  localparam int MODE_RR_BIT = 0;
  localparam int MODE_SYNC_LSB = 2;
  localparam int MODE_ASAV_BIT = 6;
  localparam int MODE_REP_BIT = 7;
  localparam int STS_SYNC_BIT = 0;
  localparam int STS_FAIL_BIT = 2;
  // link and frame sizes
  localparam int NPORT = 2;
  localparam int FRAME_W = 16;
  // transmitter rate codes
  localparam logic [1:0] RATE_1G6 = 2'h0;
  localparam logic [1:0] RATE_RSVD = 2'h1;
  localparam logic [1:0] RATE_800M = 2'h2;
  localparam logic [1:0] RATE_400M = 2'h3;
  typedef enum logic [1:0] {SYNC_OFF, SYNC_BASIC, SYNC_ILV, SYNC_CAT} csf_sync_t;
  typedef enum logic [1:0] {PK_FS, PK_FE, PK_LINE, PK_SHORT} csf_kind_t;
endpackage

// File: csf_rx_model.sv
`timescale 1ns/1ps
module csf_rx_model (
  // control
  input wire logic run_i,
  input wire logic [1:0] take_i,
  // receive pins
  output logic link_clk_o,
  output logic [1:0] avail_o,
  output logic [3:0] kind_o,
  output logic [1:0] last_o,
  output logic [15:0] data_o
);
  logic [10:0] q0[$];
  logic [10:0] q1[$];
  initial begin
    {link_clk_o, avail_o, kind_o, last_o, data_o} = '0;
  end
  // clock halts low between bursts
  always #400 if (run_i || link_clk_o) link_clk_o = ~link_clk_o;
  always @(posedge link_clk_o) begin
    if (take_i[0] && q0.size() > 0) q0.delete(0);
    if (take_i[1] && q1.size() > 0) q1.delete(0);
  end
  // pins move on the falling edge; idle data toggles so a stale byte never looks held
  always @(negedge link_clk_o) begin
    avail_o <= {q1.size() > 0, q0.size() > 0};
    if (q0.size() > 0) {kind_o[1:0], last_o[0], data_o[7:0]} <= q0[0];
    else {last_o[0], data_o[7:0]} <= {1'b0, ~data_o[7:0]};
    if (q1.size() > 0) {kind_o[3:2], last_o[1], data_o[15:8]} <= q1[0];
    else {last_o[1], data_o[15:8]} <= {1'b0, ~data_o[15:8]};
  end
  task automatic push(input int p, input logic [1:0] k, input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      if (p == 0) q0.push_back({k, i == n - 1, b + 8'(i)});
      else q1.push_back({k, i == n - 1, b + 8'(i)});
    end
  endtask
endmodule

// File: csf_sync2.sv
`timescale 1ns/1ps
module csf_sync2 import csf_pkg::*; #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // asynchronous in, synchronous out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  if (W < 1) begin : g_chk
    $error("csf_sync2: width must be at least one");
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end

  assign q_o = s2_r;
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top import csf_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic raw = 1'b0;
  logic lrun = 1'b0;
  logic rep_exp = 1'b0;
  logic lclk, v0, s0, e0, src0, v1, s1, e1, src1;
  logic [1:0] avail, take, last, k0, k1, rate;
  logic [3:0] kind;
  logic [15:0] data;
  logic [7:0] rdata, d0, d1;
  logic [12:0] cap[$];
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  csf_rx_model m (.run_i(lrun), .take_i(take), .link_clk_o(lclk), .avail_o(avail),
    .kind_o(kind), .last_o(last), .data_o(data));
  csf_forward dut_u (.CORE_CLK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .LINK_CLK_I(lclk), .RX_AVAIL_I(avail), .RX_KIND_I(kind), .RX_LAST_I(last),
    .RX_DATA_I(data), .RX_TAKE_O(take), .RAW_MODE_I(raw), .CSI0_VALID_O(v0),
    .CSI0_SOP_O(s0), .CSI0_EOP_O(e0), .CSI0_KIND_O(k0), .CSI0_SRC_O(src0),
    .CSI0_DATA_O(d0), .CSI1_VALID_O(v1), .CSI1_SOP_O(s1), .CSI1_EOP_O(e1),
    .CSI1_KIND_O(k1), .CSI1_SRC_O(src1), .CSI1_DATA_O(d1), .CSI_TX_RATE_O(rate));
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic do_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
  endtask
  // waits for the bytes and for the model to drain, then lets surplus bytes show up
  task automatic wait_bytes(input int n);
    for (int i = 0; i < 3000 && (cap.size() < n || m.q0.size() + m.q1.size() > 0); i++)
      @(posedge clk);
    repeat (40) @(posedge clk);
    chk(16'(cap.size()), 16'(n));
  endtask
  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] rv[6] = '{8'h00, 8'h04, 8'h02, 8'h30, 8'h01, 8'h00};
    logic [7:0] wv[6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hfe, 8'hff};
    logic [7:0] xv[6] = '{8'hff, 8'hff, 8'h0f, 8'hf0, 8'hce, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rd_reg(8'h1d + 8'(i), d);
      chk(d, rv[i]);
    end
    for (int i = 0; i < 6; i++) begin
      wr_reg(8'h1d + 8'(i), wv[i]);
      rd_reg(8'h1d + 8'(i), d);
      chk(d, xv[i]);
    end
    rd_reg(8'h40, d);
    chk(d, 8'h00);
  endtask
  task automatic t_rate;
    logic [7:0] d;
    logic [1:0] cv[4] = '{2'h0, 2'h3, 2'h2, 2'h1};
    logic [1:0] ev[4] = '{2'h0, 2'h3, 2'h2, 2'h2};
    @(negedge clk);
    chk(rate, 2'h2);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h1f, {6'h00, cv[i]});
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(rate, ev[i]);
    end
    rd_reg(8'h1f, d);
    chk(d, 8'h01);
  endtask
  task automatic t_frames(input logic [15:0] lim, input int n);
    logic [15:0] num;
    logic [12:0] ex;
    do_reset();
    raw <= 1'b1;
    lrun <= 1'b1;
    wr_reg(8'h1d, lim[15:8]);
    wr_reg(8'h1e, lim[7:0]);
    wr_reg(8'h20, 8'h20);
    cap.delete();
    for (int f = 0; f < n; f++) begin
      m.push(0, PK_FS, 2, 8'h55);
      m.push(0, PK_FE, 2, 8'h66);
    end
    wait_bytes(4 * n);
    for (int f = 0; f < n; f++) begin
      num = (lim == 0) ? 16'h0000 : 16'(f % lim + 1);
      for (int j = 0; j < 4; j++) begin
        ex = {(j < 2) ? PK_FS : PK_FE, !j[0], j[0], 1'b0, j[0] ? num[15:8] : num[7:0]};
        chk(cap[4*f+j], ex);
      end
    end
  endtask
  task automatic t_block;
    cap.delete();
    wr_reg(8'h20, 8'h30);
    m.push(0, PK_LINE, 3, 8'h80);
    m.push(1, PK_LINE, 3, 8'h90);
    wait_bytes(0);
    wr_reg(8'h20, 8'h20);
    m.push(1, PK_LINE, 3, 8'h90);
    m.push(0, PK_LINE, 3, 8'ha0);
    wait_bytes(3);
    for (int i = 0; i < 3; i++) chk(cap[i][8:0], {1'b0, 8'ha0 + 8'(i)});
  endtask
  task automatic t_rep;
    wr_reg(8'h20, 8'h00);
    wr_reg(8'h21, 8'h81);
    rep_exp <= 1'b1;
    cap.delete();
    for (int i = 0; i < 2; i++) begin
      m.push(0, PK_LINE, 2, 8'hc0);
      m.push(1, PK_LINE, 2, 8'hd0);
    end
    wait_bytes(8);
    for (int i = 0; i < 3; i++) chk(cap[2*i][8] ^ cap[2*i+2][8], 1'b1);
    for (int i = 0; i < 4; i++) chk(cap[2*i][8] ^ cap[2*i+1][8], 1'b0);
    wr_reg(8'h21, 8'h01);
    rep_exp <= 1'b0;
  endtask
  task automatic t_sync;
    logic [7:0] d;
    logic [12:0] ex;
    do_reset();
    lrun <= 1'b1;
    wr_reg(8'h20, 8'h00);
    wr_reg(8'h21, 8'h04);
    cap.delete();
    m.push(0, PK_LINE, 2, 8'h10);
    repeat (300) @(posedge clk);
    chk(16'(cap.size()), 16'h0);
    m.push(1, PK_LINE, 2, 8'h20);
    wait_bytes(4);
    chk({cap[0][8], cap[2][8]}, 2'b01);
    // a grouped frame start, a grouped frame end, then heads that disagree
    for (int p = 0; p < 2; p++) m.push(p, PK_FS, 2, 8'h00);
    wait_bytes(8);
    rd_reg(8'h22, d);
    chk(d, 8'h01);
    for (int p = 0; p < 2; p++) m.push(p, PK_FE, 2, 8'h00);
    m.push(0, PK_FS, 2, 8'h00);
    m.push(1, PK_LINE, 2, 8'h00);
    m.push(1, PK_FS, 2, 8'h00);
    wait_bytes(16);
    rd_reg(8'h22, d);
    chk(d, 8'h05);
    rd_reg(8'h22, d);
    chk(d, 8'h01);
    wr_reg(8'h21, 8'h44);
    cap.delete();
    m.push(0, PK_LINE, 2, 8'h30);
    wait_bytes(2);
    // concatenation ignores send-when-ready and joins both lines into one packet
    wr_reg(8'h21, 8'h4c);
    cap.delete();
    m.push(0, PK_LINE, 2, 8'h40);
    repeat (300) @(posedge clk);
    chk(16'(cap.size()), 16'h0);
    m.push(1, PK_LINE, 2, 8'h50);
    wait_bytes(4);
    for (int i = 0; i < 4; i++) begin
      ex = {PK_LINE, i == 0, i == 3, i > 1, (i > 1) ? 8'h4e + 8'(i) : 8'h40 + 8'(i)};
      chk(cap[i], ex);
    end
    wr_reg(8'h21, 8'h01);
    rd_reg(8'h22, d);
    chk(d, 8'h00);
    lrun <= 1'b0;
  endtask
  // copy port is judged on every byte, and stays quiet unless copying
  always @(negedge clk) begin
    if (v0 === 1'b1) cap.push_back({k0, s0, e0, src0, d0});
    // copy port fields hold their last byte when not copying, so only its valid is judged then
    if (rep_exp && (v0 === 1'b1 || v1 === 1'b1))
      chk({v1, s1, e1, k1, src1, d1}, {v0, s0, e0, k0, src0, d0});
    else if (v0 === 1'b1 || v1 === 1'b1)
      chk(v1, 1'b0);
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    do_reset();
    t_regs();
    do_reset();
    t_rate();
    t_frames(16'h0002, 3);
    t_frames(16'h0000, 2);
    t_block();
    t_rep();
    t_sync();
    end_sim();
  end
endmodule
